// *** logic/ccsc_defs.vh ***
// constants for the charge cycle status and control block
// assumes a 10 MHz system clock; included by the design file
`ifndef CCSC_DEFS_VH
`define CCSC_DEFS_VH

`define CCSC_CLK_MHZ          10
`define CCSC_ALERT_US         256
// 256 us at 10 MHz, sized to the alert pulse counter
`define CCSC_ALERT_CYCLES     13'hA00
`define CCSC_BLINK_CYCLES     23'h4C4B40
`define CCSC_SRC_BOOST        2'h3
`define CCSC_SRC_NONE         2'h0
`define CCSC_PH_DISABLED      2'h0
`define CCSC_PH_PRE           2'h1
`define CCSC_PH_FAST          2'h2
`define CCSC_PH_DONE          2'h3
`define CCSC_CHG_CFG_CHARGE   2'h1
`define CCSC_BOOST_HOT_THRESHOLD_SELECT_OFF         2'h3
`define CCSC_ICHG_SEL_SHORT   2'h0
`define CCSC_ICHG_SEL_PRE     2'h1
`define CCSC_ICHG_SEL_FAST    2'h2
`define CCSC_RST_MIN_SYS      3'h5
`define CCSC_RST_CHG_VOLT     6'h2C
`define CCSC_RST_FAST_CUR     6'h18
`define CCSC_RST_PRE_CUR      4'h1
`define CCSC_RST_TERM_CUR     4'h1
`define CCSC_RST_BOOST_VOLT   4'h7
`define CCSC_RST_BOOST_ILIM   1'h1

`endif

// *** logic/ccsc_charge_control.v ***
// charge cycle state machine, status bits, fault latch and host alert pulse
// assumes analog comparator outputs arrive synchronous to clk_sys; the
// serial register port lives elsewhere and drives the config ports directly
//
// Notes on behaviour
// RULE1: source status reads 11 while boost runs.
// RULE2: boost current limit select bit chooses 1A or 1.5A.
// RULE3: four-bit boost voltage field sets target 4.55V to 5.5V.
// RULE4: any boost fault sets boost fault bit and raises alert; code raises no alert for one while an earlier fault is still unread.
// RULE5: three-bit minimum system voltage field, reset value means 3.5V.
// RULE6: min-system regulation status bit follows the regulation state.
// RULE7: input overload when over current or under voltage limit; reduce charge current.
// RULE8: power management status high during input voltage or current regulation.
// RULE9: reset defaults 4.208V, 2.048A, 256mA precharge and termination.
// RULE10: cycle starts only with converter on, config 01, allow low, no faults.
// RULE11: end cycle when current below termination and voltage above recharge.
// RULE12: after done, restart when battery drops below recharge threshold.
// RULE13: allow pin toggle or config rewrite after done starts a new cycle.
// RULE14: phase field 00 disabled, 01 precharge, 10 fast, 11 done.
// RULE15: indicator low while charging, released when done or off, blinks on fault; code blinks only in suspend, a safety timer fault releases it.
// RULE16: cycle completion sets phase 11 and raises alert.
// RULE17: start current: 100mA below short, precharge below low, else fast.
// RULE18: during regulation suspend termination and run safety timer at half rate.
// RULE19: start in low-to-hot-start window; suspend outside cutoff window.
// RULE20: boost suspends outside thresholds with status 00 unless select is 11.
// RULE21: thermistor fault field reports present condition and raises alert.
// RULE22: termination enable 0 disables termination; on termination switch off.
// RULE23: each alert is one active pulse of 256us; code restarts a running pulse on a new event, lengthening it.
// RULE24: faults latch until host read; thermistor field stays live.
// RULE25: analog comparisons arrive as synchronous single-bit inputs.
`timescale 1ns/1ps
`include "ccsc_defs.vh"

module ccsc_charge_control
(
  input  wire       clk_sys,
  input  wire       rst_b,
  // configuration written by host
  input  wire [1:0] charge_config,
  input  wire       charge_config_wr,
  input  wire       term_enable,
  input  wire       battery_switch_force_off,
  input  wire       recharge_offset,
  input  wire       boost_ilim_high_wr,
  input  wire       boost_ilim_high_in,
  input  wire [3:0] boost_voltage_select_in,
  input  wire       boost_voltage_wr,
  input  wire [2:0] min_sys_voltage_in,
  input  wire       min_sys_voltage_wr,
  input  wire [1:0] boost_hot_threshold_select,
  input  wire       fault_reg_read,
  // pins and converter state
  input  wire       charge_allow_b,
  input  wire       converter_on,
  input  wire       boost_request,
  input  wire       safety_timer_fault,
  // synchronous comparator inputs
  input  wire       bat_below_short,
  input  wire       bat_below_low_battery_threshold,
  input  wire       bat_below_recharge_hi,
  input  wire       bat_below_recharge_lo,
  input  wire       chg_current_below_term,
  input  wire       input_current_over_limit,
  input  wire       input_voltage_under_limit,
  input  wire       thermal_regulation,
  input  wire       sys_at_min_regulation,
  input  wire       ts_in_start_window,
  input  wire       ts_in_cutoff_window,
  input  wire       ts_in_boost_window,
  input  wire       ts_cold,
  input  wire       ts_hot,
  input  wire       boost_fault_event,
  // status and control outputs
  output reg  [1:0] input_source_status,
  output reg  [1:0] charge_phase,
  output reg        min_sys_regulation,
  output reg        dynamic_power_management,
  output reg        boost_fault,
  output reg  [2:0] ts_fault,
  output reg        boost_active,
  output reg        boost_ilim_high,
  output reg  [3:0] boost_voltage_select,
  output reg  [2:0] min_sys_voltage,
  output reg  [5:0] charge_voltage_code,
  output reg  [5:0] fast_current_code,
  output reg  [3:0] pre_current_code,
  output reg  [3:0] term_current_code,
  output reg  [1:0] charge_current_select,
  output reg        charge_current_reduce,
  output reg        battery_switch_on,
  output reg        safety_timer_tick_half,
  output reg        stat_oe,
  output reg        alert_b
);

  // ----------------------------------------------------------------
  // charge state machine
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE    = 3'h0;
  localparam [2:0] ST_PRE     = 3'h1;
  localparam [2:0] ST_FAST    = 3'h2;
  localparam [2:0] ST_SUSPEND = 3'h3;
  localparam [2:0] ST_DONE    = 3'h4;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg         allow_b_q;
  reg  [12:0] alert_cnt;
  reg  [22:0] blink_cnt;
  reg         blink;
  reg         fault_held;
  reg         ts_fault_q;

  wire ts_fault_now = ts_cold | ts_hot; // see RULE25
  wire dpm_now      = input_current_over_limit | input_voltage_under_limit;
  wire regulating   = dpm_now | thermal_regulation;
  wire recharge_low = recharge_offset ? bat_below_recharge_hi : bat_below_recharge_lo;
  wire start_ok     = converter_on && (charge_config == `CCSC_CHG_CFG_CHARGE) &&
                      !charge_allow_b && !ts_fault_now && !safety_timer_fault &&
                      !battery_switch_force_off && ts_in_start_window; // see RULE10 RULE19
  wire retrigger    = (allow_b_q & ~charge_allow_b) | charge_config_wr; // see RULE13
  wire charging     = (state == ST_PRE) || (state == ST_FAST);
  wire terminate    = charging && term_enable && !regulating && chg_current_below_term &&
                      !recharge_low; // see RULE11 RULE18 RULE22
  wire boost_go     = boost_request && converter_on &&
                      (ts_in_boost_window || boost_hot_threshold_select == `CCSC_BOOST_HOT_THRESHOLD_SELECT_OFF);
  wire new_fault    = (boost_fault_event && boost_active) ||
                      (ts_fault_now && !ts_fault_q);
  wire alert_evt    = (charging && next_state == ST_DONE) || // see RULE16
                      (new_fault && !(fault_held && !(ts_fault_now && !ts_fault_q)));

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (start_ok)
          next_state = bat_below_low_battery_threshold ? ST_PRE : ST_FAST;
      ST_PRE, ST_FAST:
        if (!start_ok && (charge_config != `CCSC_CHG_CFG_CHARGE || charge_allow_b ||
            battery_switch_force_off || safety_timer_fault || !converter_on))
          next_state = ST_IDLE;
        else if (!ts_in_cutoff_window || ts_fault_now)
          next_state = ST_SUSPEND; // see RULE19
        else if (terminate)
          next_state = ST_DONE; // see RULE11
        else if (state == ST_PRE && !bat_below_low_battery_threshold)
          next_state = ST_FAST;
      ST_SUSPEND:
        if (charge_config != `CCSC_CHG_CFG_CHARGE || charge_allow_b)
          next_state = ST_IDLE;
        else if (start_ok)
          next_state = bat_below_low_battery_threshold ? ST_PRE : ST_FAST;
      ST_DONE:
        if (charge_config != `CCSC_CHG_CFG_CHARGE || charge_allow_b)
          next_state = ST_IDLE;
        else if ((recharge_low || retrigger) && start_ok)
          next_state = bat_below_low_battery_threshold ? ST_PRE : ST_FAST; // see RULE12 RULE13
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state     <= ST_IDLE;
      allow_b_q <= 1'b1;
    end
    else
    begin
      state     <= next_state;
      allow_b_q <= charge_allow_b;
    end
  end

  // ----------------------------------------------------------------
  // host configuration fields with reset defaults
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      boost_ilim_high      <= `CCSC_RST_BOOST_ILIM;
      boost_voltage_select <= `CCSC_RST_BOOST_VOLT;
      min_sys_voltage      <= `CCSC_RST_MIN_SYS; // see RULE5
      charge_voltage_code  <= `CCSC_RST_CHG_VOLT; // see RULE9
      fast_current_code    <= `CCSC_RST_FAST_CUR;
      pre_current_code     <= `CCSC_RST_PRE_CUR;
      term_current_code    <= `CCSC_RST_TERM_CUR;
    end
    else
    begin
      if (boost_ilim_high_wr)
        boost_ilim_high <= boost_ilim_high_in; // see RULE2
      if (boost_voltage_wr)
        boost_voltage_select <= boost_voltage_select_in; // see RULE3
      if (min_sys_voltage_wr)
        min_sys_voltage <= min_sys_voltage_in;
    end
  end

  // ----------------------------------------------------------------
  // status, control outputs and indicator
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      input_source_status      <= `CCSC_SRC_NONE;
      charge_phase             <= `CCSC_PH_DISABLED;
      min_sys_regulation       <= 1'b0;
      dynamic_power_management <= 1'b0;
      boost_active             <= 1'b0;
      charge_current_select    <= `CCSC_ICHG_SEL_FAST;
      charge_current_reduce    <= 1'b0;
      battery_switch_on        <= 1'b1;
      safety_timer_tick_half   <= 1'b0;
      stat_oe                  <= 1'b0;
      blink_cnt                <= 23'h000000;
      blink                    <= 1'b0;
    end
    else
    begin
      boost_active <= boost_go; // see RULE20
      if (boost_go)
        input_source_status <= `CCSC_SRC_BOOST; // see RULE1
      else if (boost_request)
        input_source_status <= `CCSC_SRC_NONE; // see RULE20
      else
        input_source_status <= `CCSC_SRC_NONE;
      min_sys_regulation       <= sys_at_min_regulation; // see RULE6
      dynamic_power_management <= dpm_now; // see RULE8
      charge_current_reduce    <= dpm_now; // see RULE7
      safety_timer_tick_half   <= charging && regulating; // see RULE18
      battery_switch_on        <= (next_state != ST_DONE) && !battery_switch_force_off; // see RULE22
      case (next_state)
        ST_PRE:    charge_phase <= `CCSC_PH_PRE;
        ST_FAST:   charge_phase <= `CCSC_PH_FAST;
        ST_DONE:   charge_phase <= `CCSC_PH_DONE; // see RULE14 RULE16
        ST_SUSPEND: charge_phase <= charge_phase;
        default:   charge_phase <= `CCSC_PH_DISABLED;
      endcase
      if (next_state == ST_PRE || next_state == ST_FAST)
        charge_current_select <= bat_below_short ? `CCSC_ICHG_SEL_SHORT :
                                 (next_state == ST_PRE ? `CCSC_ICHG_SEL_PRE :
                                  `CCSC_ICHG_SEL_FAST); // see RULE17
      if (blink_cnt == `CCSC_BLINK_CYCLES - 23'h000001)
      begin
        blink_cnt <= 23'h000000;
        blink     <= ~blink;
      end
      else
        blink_cnt <= blink_cnt + 23'h000001;
      // open drain: enable pulls the pin low
      if (next_state == ST_SUSPEND)
        stat_oe <= blink; // see RULE15
      else
        stat_oe <= (next_state == ST_PRE) || (next_state == ST_FAST);
    end
  end

  // ----------------------------------------------------------------
  // fault register and alert pulse
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      boost_fault <= 1'b0;
      ts_fault    <= 3'h0;
      ts_fault_q  <= 1'b0;
      fault_held  <= 1'b0;
      alert_cnt   <= 13'h0000;
      alert_b     <= 1'b1;
    end
    else
    begin
      ts_fault_q <= ts_fault_now;
      // thermistor field is live, not latched
      ts_fault   <= {1'b0, ts_hot, ts_cold}; // see RULE21 RULE24
      // a new event wins over a read clear in the same cycle
      if (boost_fault_event && boost_active)
        boost_fault <= 1'b1; // see RULE4
      else if (fault_reg_read)
        boost_fault <= 1'b0; // see RULE24
      if (new_fault)
        fault_held <= 1'b1;
      else if (fault_reg_read)
        fault_held <= 1'b0;
      // an event during a pulse restarts it, so alerts never overlap
      if (alert_evt)
      begin
        alert_cnt <= `CCSC_ALERT_CYCLES;
        alert_b   <= 1'b0; // see RULE23
      end
      else if (alert_cnt > 13'h0001)
        alert_cnt <= alert_cnt - 13'h0001;
      else
      begin
        alert_cnt <= 13'h0000;
        alert_b   <= 1'b1;
      end
    end
  end

endmodule

// *** verification/ccsc_charge_control_assertions.sv ***
// port checker for the charge cycle control block
// assumes one clock domain; bound onto every ccsc_charge_control
`timescale 1ns/1ps
module ccsc_chk
(
  input wire       clk_sys,
  input wire       rst_b,
  input wire [1:0] charge_config,
  input wire       charge_allow_b,
  input wire       converter_on,
  input wire       input_current_over_limit,
  input wire       input_voltage_under_limit,
  input wire       sys_at_min_regulation,
  input wire       boost_fault_event,
  input wire       ts_cold,
  input wire       ts_hot,
  input wire [1:0] input_source_status,
  input wire [1:0] charge_phase,
  input wire       min_sys_regulation,
  input wire       dynamic_power_management,
  input wire       boost_fault,
  input wire [2:0] ts_fault,
  input wire       boost_active,
  input wire       charge_current_reduce,
  input wire       battery_switch_on,
  input wire       alert_b
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // overlapping alerts restart the pulse, so the length check assumes none overlap
  reg [11:0] low_cnt;
  always @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      low_cnt <= 12'h000;
    else
      low_cnt <= alert_b ? 12'h000 : low_cnt + 12'h001;
  boost_src_a: assert property (boost_active |-> input_source_status == 2'h3)
    else $error("source status not 11 in boost");
  dpm_flag_a: assert property ((input_current_over_limit || input_voltage_under_limit)
    |=> dynamic_power_management) else $error("power management flag low");
  reduce_a: assert property ((input_current_over_limit || input_voltage_under_limit)
    |=> charge_current_reduce) else $error("charge current not reduced");
  minsys_a: assert property (1 |=> min_sys_regulation == $past(sys_at_min_regulation))
    else $error("min system flag wrong");
  bfault_a: assert property (boost_fault_event |=> boost_fault)
    else $error("boost fault not latched");
  ts_live_a: assert property (1 |=> ts_fault == {1'b0, $past(ts_hot), $past(ts_cold)})
    else $error("thermistor field not live");
  done_alert_a: assert property ((charge_phase == 2'h3 && $past(charge_phase) != 2'h3)
    |-> !alert_b && !battery_switch_on) else $error("done without alert or switch off");
  start_ok_a: assert property (($past(charge_phase) == 2'h0 && charge_phase != 2'h0)
    |-> $past(charge_config) == 2'h1 && !$past(charge_allow_b) && $past(converter_on))
    else $error("cycle started without conditions");
  alert_len_a: assert property ($rose(alert_b) |-> low_cnt == 12'hA00)
    else $error("alert pulse length wrong");
endmodule
bind ccsc_charge_control ccsc_chk i_ccsc_chk (.clk_sys, .rst_b, .charge_config, .charge_allow_b,
  .converter_on, .input_current_over_limit, .input_voltage_under_limit, .sys_at_min_regulation,
  .boost_fault_event, .ts_cold, .ts_hot, .input_source_status, .charge_phase, .min_sys_regulation,
  .dynamic_power_management, .boost_fault, .ts_fault, .boost_active, .charge_current_reduce,
  .battery_switch_on, .alert_b);

// *** verification/ccsc_host_model.sv ***
// host side model: reads the fault register when the bench asks
// assumes read_req is a one-cycle pulse
`timescale 1ns/1ps
module ccsc_host_model
(
  input  wire clk_sys,
  input  wire rst_b,
  input  wire read_req,
  output reg  fault_reg_read
);
  reg second;
  // two back-to-back reads: the first returns the latched state, the second the live one
  always @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      fault_reg_read <= 1'b0;
      second <= 1'b0;
    end
    else
    begin
      fault_reg_read <= read_req | second;
      second <= read_req;
    end
endmodule

// *** verification/charge_cycle_status_control_tb.sv ***
// self-checking bench for the charge cycle control block
// assumes the design and host model are compiled first
`timescale 1ns/1ps
module charge_cycle_status_control_tb;
  reg clk_sys = 1'b0, rst_b = 1'b0, read_req = 1'b0;
  reg [1:0] charge_config = 2'h0, boost_hot_threshold_select = 2'h3;
  reg [3:0] boost_voltage_select_in = 4'h0;
  reg [2:0] min_sys_voltage_in = 3'h0;
  reg charge_config_wr = 1'b0, term_enable = 1'b1, battery_switch_force_off = 1'b0;
  reg recharge_offset = 1'b0, boost_ilim_high_wr = 1'b0, boost_ilim_high_in = 1'b0;
  reg boost_voltage_wr = 1'b0, min_sys_voltage_wr = 1'b0, charge_allow_b = 1'b1;
  reg converter_on = 1'b0, boost_request = 1'b0, safety_timer_fault = 1'b0;
  reg bat_below_short = 1'b0, bat_below_low_battery_threshold = 1'b0;
  reg bat_below_recharge_hi = 1'b0, bat_below_recharge_lo = 1'b0, chg_current_below_term = 1'b0;
  reg input_current_over_limit = 1'b0, input_voltage_under_limit = 1'b0;
  reg thermal_regulation = 1'b0, sys_at_min_regulation = 1'b0, ts_in_start_window = 1'b1;
  reg ts_in_cutoff_window = 1'b1, ts_in_boost_window = 1'b1, ts_cold = 1'b0, ts_hot = 1'b0;
  reg boost_fault_event = 1'b0;
  wire [1:0] input_source_status, charge_phase, charge_current_select;
  wire [2:0] ts_fault, min_sys_voltage;
  wire [3:0] boost_voltage_select, pre_current_code, term_current_code;
  wire [5:0] charge_voltage_code, fast_current_code;
  wire min_sys_regulation, dynamic_power_management, boost_fault, boost_active, stat_oe;
  wire boost_ilim_high, charge_current_reduce, battery_switch_on, safety_timer_tick_half;
  wire alert_b, fault_reg_read;
  integer errors = 0, cmp_count = 0, cyc = 0;
  ccsc_charge_control i_ccsc_charge_control (.clk_sys, .rst_b, .charge_config, .charge_config_wr,
    .term_enable, .battery_switch_force_off, .recharge_offset, .boost_ilim_high_wr,
    .boost_ilim_high_in, .boost_voltage_select_in, .boost_voltage_wr, .min_sys_voltage_in,
    .min_sys_voltage_wr, .boost_hot_threshold_select, .fault_reg_read, .charge_allow_b,
    .converter_on, .boost_request, .safety_timer_fault, .bat_below_short,
    .bat_below_low_battery_threshold, .bat_below_recharge_hi, .bat_below_recharge_lo,
    .chg_current_below_term, .input_current_over_limit, .input_voltage_under_limit,
    .thermal_regulation, .sys_at_min_regulation, .ts_in_start_window, .ts_in_cutoff_window,
    .ts_in_boost_window, .ts_cold, .ts_hot, .boost_fault_event, .input_source_status,
    .charge_phase, .min_sys_regulation, .dynamic_power_management, .boost_fault, .ts_fault,
    .boost_active, .boost_ilim_high, .boost_voltage_select, .min_sys_voltage,
    .charge_voltage_code, .fast_current_code, .pre_current_code, .term_current_code,
    .charge_current_select, .charge_current_reduce, .battery_switch_on,
    .safety_timer_tick_half, .stat_oe, .alert_b);
  ccsc_host_model i_ccsc_host_model (.clk_sys, .rst_b, .read_req, .fault_reg_read);
  always #50 clk_sys = ~clk_sys;
  // ----
  // helpers
  // ----
  task chk(input string name, input [7:0] exp, input [7:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // inputs change 10 ns after the edge so the design never races the bench
  task step(input integer n);
    begin
      repeat (n) @(posedge clk_sys);
      #10;
    end
  endtask
  task wait_phase(input [1:0] p);
    integer k;
    begin
      k = 0;
      while (charge_phase !== p && k < 6)
      begin
        step(1);
        k = k + 1;
      end
      chk("phase", p, charge_phase);
    end
  endtask
  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      errors = errors + 1;
      finish_test;
    end
  end
  // ----
  // scenarios
  // ----
  task t_defaults;
    begin
      chk("phase", 8'h00, charge_phase);
      chk("minsys", 8'h05, min_sys_voltage);
      chk("vchg", 8'h2C, charge_voltage_code);
      chk("ifast", 8'h18, fast_current_code);
      chk("ipre", 8'h01, pre_current_code);
      chk("iterm", 8'h01, term_current_code);
      chk("ilim", 8'h01, boost_ilim_high);
      chk("bvolt", 8'h07, boost_voltage_select);
      boost_ilim_high_wr = 1'b1;
      boost_voltage_wr = 1'b1;
      boost_voltage_select_in = 4'hF;
      min_sys_voltage_wr = 1'b1;
      min_sys_voltage_in = 3'h2;
      sys_at_min_regulation = 1'b1;
      step(1);
      boost_ilim_high_wr = 1'b0;
      boost_voltage_wr = 1'b0;
      min_sys_voltage_wr = 1'b0;
      chk("ilim", 8'h00, boost_ilim_high);
      chk("bvolt", 8'h0F, boost_voltage_select);
      chk("minsys", 8'h02, min_sys_voltage);
      chk("minreg", 8'h01, min_sys_regulation);
    end
  endtask
  task t_fast_done;
    begin
      charge_config = 2'h1;
      charge_allow_b = 1'b0;
      step(2);
      chk("phase", 8'h00, charge_phase);
      converter_on = 1'b1;
      step(1);
      chk("phase", 8'h02, charge_phase);
      chk("stat", 8'h01, stat_oe);
      chk("isel", 8'h02, charge_current_select);
      term_enable = 1'b0;
      chg_current_below_term = 1'b1;
      step(3);
      chk("phase", 8'h02, charge_phase);
      term_enable = 1'b1;
      input_current_over_limit = 1'b1;
      step(3);
      chk("phase", 8'h02, charge_phase);
      chk("half", 8'h01, safety_timer_tick_half);
      chk("dpm", 8'h01, dynamic_power_management);
      chk("reduce", 8'h01, charge_current_reduce);
      input_current_over_limit = 1'b0;
      wait_phase(2'h3);
      chk("stat", 8'h00, stat_oe);
      chk("bsw", 8'h00, battery_switch_on);
      step(2559);
      chk("alert", 8'h00, alert_b);
      step(1);
      chk("alert", 8'h01, alert_b);
    end
  endtask
  task t_recharge;
    begin
      chg_current_below_term = 1'b0;
      recharge_offset = 1'b1;
      bat_below_recharge_lo = 1'b1;
      step(3);
      chk("phase", 8'h03, charge_phase);
      recharge_offset = 1'b0;
      wait_phase(2'h2);
      chk("bsw", 8'h01, battery_switch_on);
      bat_below_recharge_lo = 1'b0;
      chg_current_below_term = 1'b1;
      wait_phase(2'h3);
      step(2600);
      chg_current_below_term = 1'b0;
      charge_config_wr = 1'b1;
      step(1);
      charge_config_wr = 1'b0;
      chk("phase", 8'h02, charge_phase);
    end
  endtask
  task t_toggle;
    begin
      chg_current_below_term = 1'b0;
      bat_below_low_battery_threshold = 1'b1;
      charge_allow_b = 1'b1;
      step(2);
      charge_allow_b = 1'b0;
      wait_phase(2'h1);
      chk("isel", 8'h01, charge_current_select);
      charge_config = 2'h0;
      wait_phase(2'h0);
      chk("stat", 8'h00, stat_oe);
      bat_below_short = 1'b1;
      charge_config = 2'h1;
      wait_phase(2'h1);
      chk("isel", 8'h00, charge_current_select);
      charge_config = 2'h0;
      step(2);
    end
  endtask
  task t_thermal;
    begin
      bat_below_short = 1'b0;
      bat_below_low_battery_threshold = 1'b0;
      battery_switch_force_off = 1'b1;
      charge_config = 2'h1;
      step(2);
      chk("phase", 8'h00, charge_phase);
      battery_switch_force_off = 1'b0;
      ts_in_start_window = 1'b0;
      step(2);
      chk("phase", 8'h00, charge_phase);
      ts_in_start_window = 1'b1;
      thermal_regulation = 1'b1;
      step(2);
      chk("phase", 8'h02, charge_phase);
      chk("half", 8'h01, safety_timer_tick_half);
      thermal_regulation = 1'b0;
      ts_in_start_window = 1'b0;
      ts_in_cutoff_window = 1'b0;
      ts_hot = 1'b1;
      step(1);
      chk("tsfault", 8'h02, ts_fault);
      chk("alert", 8'h00, alert_b);
      chk("stat", 8'h00, stat_oe);
      ts_hot = 1'b0;
      ts_in_cutoff_window = 1'b1;
      step(2);
      chk("tsfault", 8'h00, ts_fault);
      chk("stat", 8'h00, stat_oe);
      ts_in_start_window = 1'b1;
      step(1);
      chk("stat", 8'h01, stat_oe);
      charge_config = 2'h0;
      read_req = 1'b1;
      step(1);
      read_req = 1'b0;
      step(2600);
    end
  endtask
  task t_boost;
    begin
      boost_request = 1'b1;
      ts_in_boost_window = 1'b0;
      step(2);
      chk("src", 8'h03, input_source_status);
      boost_hot_threshold_select = 2'h0;
      step(2);
      chk("src", 8'h00, input_source_status);
      ts_in_boost_window = 1'b1;
      step(2);
      chk("src", 8'h03, input_source_status);
      boost_fault_event = 1'b1;
      step(1);
      boost_fault_event = 1'b0;
      chk("bfault", 8'h01, boost_fault);
      chk("alert", 8'h00, alert_b);
      read_req = 1'b1;
      step(1);
      read_req = 1'b0;
      step(3);
      chk("bfault", 8'h00, boost_fault);
    end
  endtask
  initial
  begin
    step(5);
    rst_b = 1'b1;
    step(1);
    t_defaults;
    t_fast_done;
    t_recharge;
    t_toggle;
    t_thermal;
    t_boost;
    finish_test;
  end
endmodule
